//--- pkg/simd_cfg.svh
// Purpose: addresses, field positions and reset values of the simd state block
// Assumes: one aligned 32-bit word per register, byte addresses
// Notes:   included by the design; definitions only
//
// Operation
// - identification word reports the extension present through bit 26.
// - vector datapath takes 128-bit packed double or integer operands.
// - scalar double operations use only the low vector quadword.
// - below 64-bit mode exactly eight vector registers, zero to seven.
// - 64-bit mode adds registers eight to fifteen via extension prefix.
// - 32-bit control and status register governs vector floating point.
// - bit 6 of the control and status register is denormal-input-as-zero.
// - when set, denormal inputs become zero; bit 15 flushes underflowed results.
// - addresses come only from general registers, not vector or packed.
// - eight packed integer registers exchange data with vector registers.
// - some vector compares put their result in the condition flags.
// - compatibility mode behaves exactly like protected mode.
// - the wide operand prefix bit selects 64-bit general register forms.
// - an extension prefix with no meaning is silently ignored.
// - no new state; both instruction sets share it and mix freely.
// - vector registers are apart from x87 and packed integer registers.
// - save and restore cover vector registers and simd control state.
// - it runs in protected, real address and virtual 8086 modes.
// - general registers act as direct operands where defined.
// - a restored control value with reserved bits set faults.
`ifndef SIMD_CFG_SVH
`define SIMD_CFG_SVH

`define A_IDENT        32'h0000_0000
`define A_MODE         32'h0000_0004
`define A_CSR          32'h0000_0008
`define A_RESTORE      32'h0000_000C
`define A_STATUS       32'h0000_0010
`define A_FLAGS        32'h0000_0014
`define A_SELECT       32'h0000_0018
`define A_OP           32'h0000_001C
`define A_DATA0        32'h0000_0020
`define A_EADDR_LO     32'h0000_0030
`define A_EADDR_HI     32'h0000_0034
`define DATA_WORD_MASK 32'h0000_000C

`define ID_FEATURE_BIT 26
`define CSR_VALID_MASK 32'h0000_FFFF
`define CSR_RESET      32'h0000_1F80
`define CSR_IN_ZERO_BIT  6
`define CSR_OUT_ZERO_BIT 15
`define ST_FAULT_BIT   0
`define FLG_CF_BIT     0
`define FLG_ZF_BIT     6
`define OP_WIDTH       15
`define SEL_WIDTH      6

`endif

//--- pkg/simd_pkg.sv
// Purpose: types of the simd state block
// Assumes: field layout of select and operation words set by these structs
// Notes:   enumerations carry no explicit codes
package simd_pkg;

    typedef enum logic [2:0] {
        MODE_REAL, MODE_PROT, MODE_V86, MODE_COMPAT, MODE_LONG
    } mode_e;

    typedef enum logic [3:0] {
        OP_NOP, OP_MOVP, OP_MOVS, OP_PADD, OP_V2Q,
        OP_Q2V, OP_G2V, OP_V2G, OP_CMP, OP_ADDR
    } opcode_e;

    typedef enum logic [1:0] {
        FILE_VEC, FILE_PINT, FILE_GPR
    } file_e;

    typedef struct packed {
        logic       wide;
        logic [1:0] lane;
        logic       src_ext;
        logic [2:0] src;
        logic       dst_ext;
        logic [2:0] dst;
        opcode_e    code;
    } op_s;

    typedef struct packed {
        file_e      file;
        logic       ext;
        logic [2:0] idx;
    } sel_s;

endpackage : simd_pkg

//--- src/simd_ext2_register_state.sv
// Purpose: simd register state with an ahb-lite register window
// Assumes: single word transfers, one master, hreadyout is the bus hready
// Notes:   reads take one wait state, writes none
`timescale 1ns/10ps
`include "simd_cfg.svh"

module simd_ext2_register_state (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             restore_fault
);
    import simd_pkg::*;

    // separate files, no aliasing with x87 or packed regs
    logic [127:0] vec_q  [0:15];
    logic [63:0]  pint_q [0:7];
    logic [63:0]  gpr_q  [0:7];

    logic [31:0] a_q;
    logic        wr_q;
    logic        rd_q;
    logic [31:0] hrdata_q;
    logic [31:0] csr_q;
    logic [31:0] flags_q;
    logic [63:0] ea_q;
    logic        fault_q;
    mode_e       mode_q;
    sel_s        sel_q;

    // bus address phase
    wire take = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_q  <= 32'h0000_0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= take & hwrite;
            rd_q <= take & ~hwrite;
            if (take) begin
                a_q <= haddr;
            end
        end
    end

    // the wait state lets a read see a write done one cycle earlier
    assign hreadyout     = ~rd_q;
    assign hresp         = 1'b0;
    assign hrdata        = hrdata_q;
    assign restore_fault = fault_q;

    wire we_mode  = wr_q & (a_q == `A_MODE);
    wire we_csr   = wr_q & (a_q == `A_CSR);
    wire we_rest  = wr_q & (a_q == `A_RESTORE);
    wire we_stat  = wr_q & (a_q == `A_STATUS);
    wire we_sel   = wr_q & (a_q == `A_SELECT);
    wire go       = wr_q & (a_q == `A_OP);
    wire in_data  = (a_q & ~`DATA_WORD_MASK) == `A_DATA0;
    wire we_data  = wr_q & in_data;
    wire [1:0] wk = a_q[3:2];

    // compat, protected, real and v86 all take the 8-register path
    wire mode64 = (mode_q == MODE_LONG);

    // operation fields
    op_s op;
    assign op = op_s'(hwdata[`OP_WIDTH-1:0]);

    // extension bit counts only in 64-bit mode, otherwise dropped
    wire [3:0] dv = {op.dst_ext & mode64, op.dst};
    wire [3:0] sv = {op.src_ext & mode64, op.src};
    wire [3:0] wv = {sel_q.ext & mode64, sel_q.idx};
    wire       wide = op.wide & mode64;

    wire [127:0] src128 = vec_q[sv];
    wire [127:0] dst128 = vec_q[dv];
    wire [63:0]  gsrc   = gpr_q[op.src];
    wire [63:0]  gsel   = wide ? gsrc : {32'h0000_0000, gsrc[31:0]};

    wire in_zero_en  = csr_q[`CSR_IN_ZERO_BIT];
    wire out_zero_en = csr_q[`CSR_OUT_ZERO_BIT];

    function automatic logic [63:0] zap(input logic [63:0] x, input logic en);
        logic den;
        den = (x[62:52] == 11'h000) && (x[51:0] != 52'h0);
        zap = (en && den) ? {x[63], 63'h0} : x;
    endfunction : zap

    // denormal input zeroed, then underflowed output flushed
    wire [63:0] scal = zap(zap(src128[63:0], in_zero_en),
                           out_zero_en);

    // packed integer add; carry broken at lane edges
    logic [127:0] psum;
    logic [16:0]  pc;
    assign pc[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_lane
            wire brk = (op.lane == 2'h0) |
                       ((op.lane == 2'h1) & (gi % 2 == 0)) |
                       ((op.lane == 2'h2) & (gi % 4 == 0)) |
                       ((op.lane == 2'h3) & (gi % 8 == 0));
            wire [8:0] s = {1'b0, dst128[gi*8 +: 8]} +
                           {1'b0, src128[gi*8 +: 8]} +
                           {8'h00, pc[gi] & ~brk};
            assign psum[gi*8 +: 8] = s[7:0];
            assign pc[gi+1]        = s[8];
        end
    endgenerate

    // vector write port
    logic         vwe;
    logic [3:0]   vwa;
    logic [127:0] vwd;
    logic [127:0] vwm;

    always_comb begin
        vwe = 1'b0;
        vwa = dv;
        vwd = 128'h0;
        vwm = 128'h0;
        if (go) begin
            case (op.code)
                OP_MOVP: begin
                    vwe = 1'b1;
                    vwd = src128;
                    vwm = ~128'h0;
                end
                OP_MOVS: begin
                    vwe = 1'b1;
                    vwd = {64'h0, scal};
                    vwm = {64'h0, ~64'h0};
                end
                OP_PADD: begin
                    vwe = 1'b1;
                    vwd = psum;
                    vwm = ~128'h0;
                end
                OP_Q2V: begin
                    vwe = 1'b1;
                    vwd = {64'h0, pint_q[op.src]};
                    vwm = ~128'h0;
                end
                OP_G2V: begin
                    vwe = 1'b1;
                    vwd = {64'h0, gsel};
                    vwm = ~128'h0;
                end
                default: begin
                    vwe = 1'b0;
                end
            endcase
        end else if (we_data && sel_q.file == FILE_VEC) begin
            vwe = 1'b1;
            vwa = wv;
            vwd = {4{hwdata}};
            vwm = {96'h0, ~32'h0} << {wk, 5'h00};
        end
    end

    // packed integer and general register write ports
    wire pwe_op  = go & (op.code == OP_V2Q);
    wire pwe_win = we_data & (sel_q.file == FILE_PINT) & ~wk[1];
    wire gwe_op  = go & (op.code == OP_V2G);
    wire gwe_win = we_data & (sel_q.file == FILE_GPR) & ~wk[1];
    wire [63:0] wmask = wk[0] ? {~32'h0, 32'h0} : {32'h0, ~32'h0};
    wire [63:0] v2g   = wide ? src128[63:0] : {32'h0, src128[31:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++) vec_q[i] <= 128'h0;
        end else if (vwe) begin
            vec_q[vwa] <= (vec_q[vwa] & ~vwm) | (vwd & vwm);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) pint_q[i] <= 64'h0;
        end else if (pwe_op) begin
            pint_q[op.dst] <= src128[63:0];
        end else if (pwe_win) begin
            pint_q[sel_q.idx] <= (pint_q[sel_q.idx] & ~wmask) |
                                 ({2{hwdata}} & wmask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) gpr_q[i] <= 64'h0;
        end else if (gwe_op) begin
            gpr_q[op.dst] <= v2g;
        end else if (gwe_win) begin
            gpr_q[sel_q.idx] <= (gpr_q[sel_q.idx] & ~wmask) |
                                ({2{hwdata}} & wmask);
        end
    end

    // control and status; one copy shared by both instruction sets
    wire       rest_bad  = (hwdata & ~`CSR_VALID_MASK) != 32'h0;
    wire       fault_clr = we_stat & hwdata[`ST_FAULT_BIT];
    wire       fault_set = we_rest & rest_bad;
    wire [2:0] mode_w    = hwdata[2:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csr_q <= `CSR_RESET;
        end else if (we_csr) begin
            csr_q <= hwdata & `CSR_VALID_MASK;
        end else if (we_rest && !rest_bad) begin
            csr_q <= hwdata;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_set | (fault_q & ~fault_clr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= MODE_REAL;
            sel_q  <= sel_s'(`SEL_WIDTH'h0);
        end else begin
            if (we_mode && mode_w <= MODE_LONG) begin
                mode_q <= mode_e'(mode_w);
            end
            if (we_sel) begin
                sel_q <= sel_s'(hwdata[`SEL_WIDTH-1:0]);
            end
        end
    end

    // compare of low quadwords lands in the flags word
    wire cmp_eq = dst128[63:0] == src128[63:0];
    wire cmp_lt = dst128[63:0] <  src128[63:0];
    wire [63:0] ea_sum = gpr_q[op.dst] + gpr_q[op.src];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 32'h0000_0000;
            ea_q    <= 64'h0;
        end else if (go && op.code == OP_CMP) begin
            flags_q[`FLG_ZF_BIT] <= cmp_eq;
            flags_q[`FLG_CF_BIT] <= cmp_lt;
        end else if (go && op.code == OP_ADDR) begin
            // base plus index from general registers only
            ea_q <= mode64 ? ea_sum : {32'h0, ea_sum[31:0]};
        end
    end

    // read mux
    wire [127:0] wvec = vec_q[wv];
    wire [63:0]  wpi  = (sel_q.file == FILE_PINT) ? pint_q[sel_q.idx] :
                                                    gpr_q[sel_q.idx];
    wire [31:0]  win_w =
        (sel_q.file == FILE_VEC) ? wvec[{wk, 5'h00} +: 32] :
        (sel_q.file == FILE_GPR || sel_q.file == FILE_PINT) ?
            (wk[1] ? 32'h0 : wpi[{wk[0], 5'h00} +: 32]) : 32'h0;
    wire [31:0] ident = 32'h1 << `ID_FEATURE_BIT;

    wire [31:0] rd_mux =
        (a_q == `A_IDENT)    ? ident :
        (a_q == `A_MODE)     ? {29'h0, mode_q} :
        (a_q == `A_CSR)      ? csr_q :
        (a_q == `A_STATUS)   ? {31'h0, fault_q} :
        (a_q == `A_FLAGS)    ? flags_q :
        (a_q == `A_SELECT)   ? {26'h0, sel_q} :
        (a_q == `A_EADDR_LO) ? ea_q[31:0] :
        (a_q == `A_EADDR_HI) ? ea_q[63:32] :
        in_data              ? win_w : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_q) begin
            hrdata_q <= rd_mux;
        end
    end

    // checks
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    rd_wait_state_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_q |-> s_read_wait)
        else $error("read did not take exactly one wait state");

    ident_bit_fixed_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_q && a_q == `A_IDENT |=> hrdata == (32'h1 << `ID_FEATURE_BIT))
        else $error("identification word wrong");

    ext_reg_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        vwe && !mode64 |-> !vwa[3])
        else $error("upper vector register written outside 64-bit mode");

    scalar_high_kept_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        go && op.code == OP_MOVS |=>
            vec_q[$past(dv)][127:64] == $past(dst128[127:64]))
        else $error("scalar move touched the high quadword");

    denorm_zeroed_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        go && op.code == OP_MOVS && in_zero_en &&
        src128[62:52] == 11'h000 |=> vec_q[$past(dv)][62:0] == 63'h0)
        else $error("denormal input not zeroed");

    sequence s_bad_restore;
        we_rest && rest_bad;
    endsequence

    restore_fault_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_bad_restore |=> fault_q && $stable(csr_q))
        else $error("bad restore did not fault or changed control");

    csr_reserved_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (csr_q & ~`CSR_VALID_MASK) == 32'h0)
        else $error("reserved control bit set");

    cmp_flags_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        go && op.code == OP_CMP |=>
            flags_q[`FLG_ZF_BIT] == $past(cmp_eq))
        else $error("compare result missing from flags");

    narrow_gpr_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        go && op.code == OP_V2G && !mode64 |=>
            gpr_q[$past(op.dst)][63:32] == 32'h0)
        else $error("narrow form wrote upper general register half");

    fault_sticky_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fault_q && !fault_clr |=> fault_q)
        else $error("fault flag dropped without a clear");

endmodule : simd_ext2_register_state

//--- bench/simd_ext2_register_state_bench.sv
// Purpose: self-checking bench for the simd state block
// Assumes: single word ahb-lite transfers, hready looped from hreadyout
// Notes:   hsel and hsize tied, no other input is left constant
`timescale 1ns/10ps
`include "simd_cfg.svh"

module simd_ext2_register_state_bench;
    import simd_pkg::*;

    logic         hclk;
    logic         hresetn;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [31:0]  hwdata;
    logic         hready;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic         restore_fault;
    logic [31:0]  rv;
    logic [127:0] pa;
    logic [127:0] pb;
    int           mismatches;
    int           tests_run;

    assign hready = hreadyout;

    simd_ext2_register_state u_dut (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (1'h1),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (3'h2),
        .hwdata        (hwdata),
        .hready        (hready),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .hrdata        (hrdata),
        .restore_fault (restore_fault)
    );

    initial hclk = 1'h0;
    always #20 hclk = ~hclk;

    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // master holds each phase until hready is seen high at an edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'h1;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'h0;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        d = hrdata;
    endtask : rd

    task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                       input string nm);
        logic [31:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask : rdc

    task automatic sel_w(input file_e f, input logic [3:0] i);
        sel_s s;
        s = '{file: f, ext: i[3], idx: i[2:0]};
        wr(`A_SELECT, {26'h0, s});
    endtask : sel_w

    task automatic v_wr(input file_e f, input logic [3:0] i,
                        input logic [127:0] v);
        sel_w(f, i);
        for (int k = 0; k < 4; k++)
            wr(`A_DATA0 + 32'(4 * k), v[32*k +: 32]);
    endtask : v_wr

    task automatic v_chk(input file_e f, input logic [3:0] i,
                         input logic [127:0] e, input string nm);
        sel_w(f, i);
        for (int k = 0; k < 4; k++)
            rdc(`A_DATA0 + 32'(4 * k), e[32*k +: 32], nm);
    endtask : v_chk

    // d and s carry the extension bit on top; lw is {wide, lane}
    task automatic op_w(input opcode_e c, input logic [3:0] d,
                        input logic [3:0] s, input logic [2:0] lw);
        op_s o;
        o = '{wide: lw[2], lane: lw[1:0], src_ext: s[3], src: s[2:0],
              dst_ext: d[3], dst: d[2:0], code: c};
        wr(`A_OP, {17'h0, o});
    endtask : op_w

    // lane-wise add without carries across lanes
    function automatic logic [127:0] padd(input logic [127:0] a,
                                          input logic [127:0] b,
                                          input int w);
        logic [127:0] h;
        h = '0;
        for (int i = w - 1; i < 128; i += w)
            h[i] = 1'h1;
        return ((a & ~h) + (b & ~h)) ^ ((a ^ b) & h);
    endfunction : padd

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        end_sim();
    end

    initial begin
        hresetn = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(`A_IDENT, rv);
        chk("ident", 32'h1, {31'h0, rv[`ID_FEATURE_BIT]});
        rdc(`A_CSR, `CSR_RESET, "csr_rst");
        rdc(`A_MODE, 32'h0, "mode_rst");
        rdc(`A_STATUS, 32'h0, "stat_rst");
        rdc(32'h0000_0040, 32'h0, "unmapped");
        chk("hresp", 32'h0, {31'h0, hresp});
        wr(`A_CSR, 32'hFFFF_FFFF);
        rdc(`A_CSR, 32'h0000_FFFF, "csr_mask");
        // faulting restore must leave the control register alone
        wr(`A_CSR, `CSR_RESET);
        wr(`A_RESTORE, 32'h0001_1FC0);
        rdc(`A_CSR, `CSR_RESET, "csr_keep");
        chk("fault", 32'h1, {31'h0, restore_fault});
        rdc(`A_STATUS, 32'h1, "stat_set");
        wr(`A_STATUS, 32'h1);
        // the clear lands at the edge that ends the write
        @(posedge hclk);
        chk("fault_clr", 32'h0, {31'h0, restore_fault});
        wr(`A_RESTORE, `CSR_RESET | 32'h0000_0040);
        rdc(`A_CSR, 32'h0000_1FC0, "csr_load");
        wr(`A_MODE, 32'h1);
        wr(`A_MODE, 32'h5);
        rdc(`A_MODE, 32'h1, "mode_bad");
        // denormal source: copied with both controls off, else zero
        for (int k = 0; k < 3; k++) begin
            wr(`A_CSR, k == 0 ? `CSR_RESET :
               k == 1 ? 32'h0000_1FC0 : 32'h0000_9F80);
            v_wr(FILE_VEC, 4'h0, {64'hAAAA_5555_AAAA_5555, 64'h1});
            v_wr(FILE_VEC, 4'h7, {64'h1111_2222_3333_4444, 64'h9});
            op_w(OP_MOVS, 4'h7, 4'h0, 3'h0);
            v_chk(FILE_VEC, 4'h7, {64'h1111_2222_3333_4444,
                  k == 0 ? 64'h1 : 64'h0}, "movs");
        end
        pa = {8{16'hFFFF}};
        pb = {16{8'h01}};
        for (int l = 0; l < 4; l++) begin
            v_wr(FILE_VEC, 4'h1, pa);
            v_wr(FILE_VEC, 4'h2, pb);
            op_w(OP_PADD, 4'h1, 4'h2, 3'(l));
            v_chk(FILE_VEC, 4'h1, padd(pa, pb, 8 << l), "padd");
        end
        // extension bit must not reach upper registers below 64-bit mode
        for (int m = 0; m < 4; m++) begin
            wr(`A_MODE, 32'(m));
            v_wr(FILE_VEC, 4'h8, {4{32'hC0DE_0000 | 32'(m)}});
            v_chk(FILE_VEC, 4'h0, {4{32'hC0DE_0000 | 32'(m)}},
                  "noext");
            op_w(OP_MOVP, 4'hD, 4'h8, 3'h0);
            v_chk(FILE_VEC, 4'h5, {4{32'hC0DE_0000 | 32'(m)}},
                  "movp");
        end
        wr(`A_MODE, 32'h4);
        v_wr(FILE_VEC, 4'h8, {4{32'h8888_0008}});
        v_chk(FILE_VEC, 4'h0, {4{32'hC0DE_0003}}, "low_keep");
        op_w(OP_MOVP, 4'hF, 4'h8, 3'h0);
        v_chk(FILE_VEC, 4'hF, {4{32'h8888_0008}}, "ext15");
        v_wr(FILE_GPR, 4'h1, {64'h0, 64'h1_FFFF_FFF0});
        v_wr(FILE_GPR, 4'h2, {64'h0, 64'h20});
        op_w(OP_G2V, 4'h6, 4'h1, 3'h4);
        v_chk(FILE_VEC, 4'h6, {64'h0, 64'h1_FFFF_FFF0}, "g2v_w");
        op_w(OP_ADDR, 4'h1, 4'h2, 3'h0);
        rdc(`A_EADDR_LO, 32'h10, "ea_lo");
        rdc(`A_EADDR_HI, 32'h2, "ea_hi");
        wr(`A_MODE, 32'h1);
        op_w(OP_G2V, 4'h6, 4'h1, 3'h4);
        v_chk(FILE_VEC, 4'h6, {96'h0, 32'hFFFF_FFF0}, "g2v");
        op_w(OP_ADDR, 4'h1, 4'h2, 3'h0);
        rdc(`A_EADDR_HI, 32'h0, "ea32");
        v_wr(FILE_VEC, 4'h3, {64'h7, 64'h0123_4567_89AB_CDEF});
        op_w(OP_V2Q, 4'h2, 4'h3, 3'h0);
        v_wr(FILE_VEC, 4'h3, 128'h0);
        v_chk(FILE_PINT, 4'h2, {64'h0, 64'h0123_4567_89AB_CDEF},
              "pint");
        op_w(OP_Q2V, 4'h4, 4'h2, 3'h0);
        v_chk(FILE_VEC, 4'h4, {64'h0, 64'h0123_4567_89AB_CDEF},
              "q2v");
        op_w(OP_CMP, 4'h4, 4'h4, 3'h0);
        rd(`A_FLAGS, rv);
        chk("eq", 32'h1, {31'h0, rv[`FLG_ZF_BIT]});
        chk("ge", 32'h0, {31'h0, rv[`FLG_CF_BIT]});
        op_w(OP_CMP, 4'h3, 4'h4, 3'h0);
        rd(`A_FLAGS, rv);
        chk("ne", 32'h0, {31'h0, rv[`FLG_ZF_BIT]});
        chk("lt", 32'h1, {31'h0, rv[`FLG_CF_BIT]});
        // wide bit set but ignored outside 64-bit mode
        op_w(OP_V2G, 4'h3, 4'h4, 3'h4);
        v_chk(FILE_GPR, 4'h3, {96'h0, 32'h89AB_CDEF},
              "v2g");
        wr(`A_MODE, 32'h4);
        op_w(OP_V2G, 4'h3, 4'h4, 3'h4);
        v_chk(FILE_GPR, 4'h3, {64'h0, 64'h0123_4567_89AB_CDEF},
              "v2g_w");
        wr(`A_IDENT, 32'h0);
        rd(`A_IDENT, rv);
        chk("ident_ro", 32'h1, {31'h0, rv[`ID_FEATURE_BIT]});
        end_sim();
    end

endmodule : simd_ext2_register_state_bench
